//--- pkg/alp_params.svh
// constants for the access level protection block
`ifndef ALP_PARAMS_SVH
`define ALP_PARAMS_SVH
`define ALP_AW 32
`define ALP_DW 32
`define ALP_PAGE_LSB 12
`define ALP_PAGE_W 20
`define ALP_IDX_W 3
`define ALP_ENTRIES 8
`define ALP_LVL_W 3
`define ALP_LVL_MAX 3'h7
`define ALP_FC_W 4
`define ALP_FC_DMA 3
`define ALP_FC_SUP 2
`define ALP_RA_W 4
`define ALP_OFS_CTRL 4'h0
`define ALP_OFS_TASK 4'h1
`define ALP_OFS_ROOT 4'h2
`define ALP_OFS_STAT 4'h3
`define ALP_OFS_MASK 4'h4
`define ALP_OFS_WALK 4'h5
`define ALP_AC_W 3
`define ALP_AC_EN 0
`define ALP_AC_LC_LO 1
`define ALP_AC_LC_HI 2
`define ALP_AC_RST 3'h0
`define ALP_LC_1BIT 2'h0
`define ALP_LC_2BIT 2'h1
`define ALP_EV_W 3
`define ALP_EV_TASK 0
`define ALP_EV_FAULT 1
`define ALP_EV_WP 2
`define ALP_EV_RST 3'h0
`define ALP_ROOT_RST 32'h0000_0000
`define ALP_TASK_RST 3'h0
`endif

//--- pkg/alp_pkg.sv
// types shared by the access level protection block
`include "alp_params.svh"
package alp_pkg;
  typedef struct packed {
    logic [`ALP_AW-1:0] addr;
    logic [`ALP_FC_W-1:0] fc;
    logic write;
  } alp_cyc_t;
  typedef struct packed {
    logic long_fmt;
    logic [`ALP_LVL_W-1:0] read_level_field;
    logic [`ALP_LVL_W-1:0] write_level_field;
    logic wp;
    logic last;
    logic [`ALP_PAGE_W-1:0] phys;
  } alp_desc_t;
  typedef struct packed {
    logic [`ALP_FC_W+`ALP_PAGE_W-1:0] tag;
    logic [`ALP_PAGE_W-1:0] phys;
    logic fault;
    logic wp;
  } alp_entry_t;
  typedef enum logic [2:0] {
    ALP_ST_IDLE = 3'b001,
    ALP_ST_CHECK = 3'b010,
    ALP_ST_WALK = 3'b100
  } alp_state_t;
endpackage : alp_pkg

//--- verilog/alp_cache_mem.sv
// translation cache entry storage with registered read data
`timescale 1ns/100ps
`include "alp_params.svh"
module alp_cache_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // write side
  input wire logic wr_en,
  input wire logic [`ALP_IDX_W-1:0] wr_idx,
  input wire alp_pkg::alp_entry_t wr_data,
  // read side
  input wire logic [`ALP_IDX_W-1:0] rd_idx,
  output alp_pkg::alp_entry_t rd_data
);
  import alp_pkg::*;

  alp_entry_t mem [`ALP_ENTRIES];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule : alp_cache_mem

//--- verilog/alp_level_check.sv
// access level check, translation cache lookup and search result capture
// Operation
// - level width is one, two or three bits per level count field
// - level zero most privileged; larger values less privileged
// - requested level taken from top address bits per configured width
// - read needs page read level; write also needs page write level
// - search compares requested level with each long descriptor's fields
// - effective read level is smallest read level seen on the path
// - cycle allowed only if requested level >= task level
// - disallowed access ends with bus error
// - task level check applies to user cycles when enabled
// - cache key is the page address bits plus function code
// - hit: fault, or write-protect on write, gives bus error
// - miss triggers a table search that builds a new entry
// - read level below requested level sets entry fault flag
// - write level below requested, or any wp bit, sets entry wp
// - supervisor cycles skip the task level check
// - dma cycles skip task check but keep search level checks
`timescale 1ns/100ps
`include "alp_params.svh"
module alp_level_check (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [`ALP_RA_W-1:0] reg_addr,
  input wire logic [`ALP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`ALP_DW-1:0] reg_rdata,
  // bus cycle from the processor
  input wire logic cyc_valid,
  input wire alp_pkg::alp_cyc_t cyc_req,
  output logic cyc_ready,
  output logic cyc_done,
  output logic cyc_entry_fault_flag,
  output logic [`ALP_AW-1:0] cyc_phys,
  // table search
  output logic walk_req,
  output alp_pkg::alp_cyc_t walk_cyc,
  output logic [`ALP_AW-1:0] walk_root,
  input wire logic desc_valid,
  input wire alp_pkg::alp_desc_t desc,
  // interrupt
  output logic irq
);
  import alp_pkg::*;

  // register state
  logic [`ALP_AC_W-1:0] access_control_reg;
  logic [`ALP_AC_W-1:0] access_control_next;
  logic [`ALP_LVL_W-1:0] task_level_reg;
  logic [`ALP_LVL_W-1:0] task_level_next;
  logic [`ALP_AW-1:0] task_root_pointer_reg;
  logic [`ALP_AW-1:0] task_root_pointer_next;
  logic [`ALP_EV_W-1:0] stat_reg;
  logic [`ALP_EV_W-1:0] stat_next;
  logic [`ALP_EV_W-1:0] mask_reg;
  logic [`ALP_EV_W-1:0] mask_next;
  logic [`ALP_DW-1:0] rdata_reg;
  logic [`ALP_DW-1:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  // cycle state
  alp_state_t state_reg;
  alp_state_t state_next;
  alp_cyc_t cur_reg;
  alp_cyc_t cur_next;
  logic [`ALP_LVL_W-1:0] lvl_reg;
  logic [`ALP_LVL_W-1:0] lvl_next;
  logic [`ALP_LVL_W-1:0] min_ral_reg;
  logic [`ALP_LVL_W-1:0] min_ral_next;
  logic [`ALP_LVL_W-1:0] min_wal_reg;
  logic [`ALP_LVL_W-1:0] min_wal_next;
  logic wp_any_reg;
  logic wp_any_next;
  logic [`ALP_ENTRIES-1:0] valid_reg;
  logic [`ALP_ENTRIES-1:0] valid_next;
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic entry_fault_flag_reg;
  logic entry_fault_flag_next;
  logic [`ALP_AW-1:0] phys_reg;
  logic [`ALP_AW-1:0] phys_next;
  logic walk_req_reg;
  logic walk_req_next;

  // combinational helpers
  logic enabled;
  logic [1:0] level_count_field;
  logic flush;
  logic [`ALP_EV_W-1:0] ev;
  logic [`ALP_IDX_W-1:0] cur_idx;
  logic [`ALP_FC_W+`ALP_PAGE_W-1:0] cur_key;
  logic mem_wr;
  alp_entry_t mem_wdata;
  alp_entry_t mem_rdata;
  logic [`ALP_LVL_W-1:0] ral_cand;
  logic [`ALP_LVL_W-1:0] wal_cand;
  logic wp_cand;
  logic fault_new;
  logic wp_new;

  assign enabled = access_control_reg[`ALP_AC_EN];
  assign level_count_field = access_control_reg[`ALP_AC_LC_HI:`ALP_AC_LC_LO];
  assign cur_idx = cur_reg.addr[`ALP_PAGE_LSB+`ALP_IDX_W-1:`ALP_PAGE_LSB];
  assign cur_key = {cur_reg.fc, cur_reg.addr[`ALP_AW-1:`ALP_PAGE_LSB]};

  // requested level from the top address bits, zero extended
  function automatic logic [`ALP_LVL_W-1:0] req_level(
    input logic [`ALP_AW-1:0] a,
    input logic [1:0] lc
  );
    logic [`ALP_LVL_W-1:0] l;
    l = '0;
    case (lc)
      `ALP_LC_1BIT: begin
        l = {2'h0, a[`ALP_AW-1]};
      end
      `ALP_LC_2BIT: begin
        l = {1'h0, a[`ALP_AW-1:`ALP_AW-2]};
      end
      default: begin
        l = a[`ALP_AW-1:`ALP_AW-3];
      end
    endcase
    return l;
  endfunction : req_level

  // register port and interrupt
  always_comb begin
    access_control_next = access_control_reg;
    task_level_next = task_level_reg;
    task_root_pointer_next = task_root_pointer_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    rdata_next = '0;
    flush = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `ALP_OFS_CTRL: begin
          access_control_next = reg_wdata[`ALP_AC_W-1:0];
          flush = 1'b1;
        end
        `ALP_OFS_TASK: begin
          task_level_next = reg_wdata[`ALP_LVL_W-1:0];
        end
        `ALP_OFS_ROOT: begin
          task_root_pointer_next = reg_wdata;
          flush = 1'b1;
        end
        `ALP_OFS_STAT: begin
          stat_next = stat_reg & ~reg_wdata[`ALP_EV_W-1:0];
        end
        `ALP_OFS_MASK: begin
          mask_next = reg_wdata[`ALP_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    stat_next = stat_next | ev;
    if (reg_rd) begin
      case (reg_addr)
        `ALP_OFS_CTRL: begin
          rdata_next[`ALP_AC_W-1:0] = access_control_reg;
        end
        `ALP_OFS_TASK: begin
          rdata_next[`ALP_LVL_W-1:0] = task_level_reg;
        end
        `ALP_OFS_ROOT: begin
          rdata_next = task_root_pointer_reg;
        end
        `ALP_OFS_STAT: begin
          rdata_next[`ALP_EV_W-1:0] = stat_reg;
        end
        `ALP_OFS_MASK: begin
          rdata_next[`ALP_EV_W-1:0] = mask_reg;
        end
        `ALP_OFS_WALK: begin
          rdata_next[3*`ALP_LVL_W-1:0] = {min_wal_reg, min_ral_reg, lvl_reg};
        end
        default: begin
        end
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      access_control_reg <= `ALP_AC_RST;
      task_level_reg <= `ALP_TASK_RST;
      task_root_pointer_reg <= `ALP_ROOT_RST;
      stat_reg <= `ALP_EV_RST;
      mask_reg <= `ALP_EV_RST;
      rdata_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      access_control_reg <= access_control_next;
      task_level_reg <= task_level_next;
      task_root_pointer_reg <= task_root_pointer_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // search accumulation for the descriptor now arriving
  always_comb begin
    ral_cand = min_ral_reg;
    wal_cand = min_wal_reg;
    wp_cand = wp_any_reg | desc.wp;
    if (desc.long_fmt) begin
      if (desc.read_level_field < min_ral_reg) begin
        ral_cand = desc.read_level_field;
      end
      if (desc.write_level_field < min_wal_reg) begin
        wal_cand = desc.write_level_field;
      end
    end
    // smallest field below the level means some field was below it
    fault_new = enabled && (ral_cand < lvl_reg);
    wp_new = wp_cand || (enabled && (wal_cand < lvl_reg));
  end

  // cycle handling
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    lvl_next = lvl_reg;
    min_ral_next = min_ral_reg;
    min_wal_next = min_wal_reg;
    wp_any_next = wp_any_reg;
    valid_next = valid_reg;
    done_next = 1'b0;
    entry_fault_flag_next = 1'b0;
    phys_next = phys_reg;
    walk_req_next = 1'b0;
    ev = '0;
    mem_wr = 1'b0;
    mem_wdata = '0;
    case (state_reg)
      ALP_ST_IDLE: begin
        if (cyc_valid && ready_reg) begin
          cur_next = cyc_req;
          lvl_next = req_level(cyc_req.addr, level_count_field);
          state_next = ALP_ST_CHECK;
        end
      end
      ALP_ST_CHECK: begin
        state_next = ALP_ST_IDLE;
        if (enabled && !cur_reg.fc[`ALP_FC_DMA]
            && !cur_reg.fc[`ALP_FC_SUP]
            && (lvl_reg < task_level_reg)) begin
          done_next = 1'b1;
          entry_fault_flag_next = 1'b1;
          ev[`ALP_EV_TASK] = 1'b1;
        end else if (valid_reg[cur_idx] && mem_rdata.tag == cur_key) begin
          done_next = 1'b1;
          if (mem_rdata.fault) begin
            entry_fault_flag_next = 1'b1;
            ev[`ALP_EV_FAULT] = 1'b1;
          end else if (mem_rdata.wp && cur_reg.write) begin
            entry_fault_flag_next = 1'b1;
            ev[`ALP_EV_WP] = 1'b1;
          end else begin
            phys_next = {mem_rdata.phys,
                         cur_reg.addr[`ALP_PAGE_LSB-1:0]};
          end
        end else begin
          walk_req_next = 1'b1;
          min_ral_next = `ALP_LVL_MAX;
          min_wal_next = `ALP_LVL_MAX;
          wp_any_next = 1'b0;
          state_next = ALP_ST_WALK;
        end
      end
      ALP_ST_WALK: begin
        if (desc_valid) begin
          min_ral_next = ral_cand;
          min_wal_next = wal_cand;
          wp_any_next = wp_cand;
          if (desc.last) begin
            mem_wr = 1'b1;
            mem_wdata.tag = cur_key;
            mem_wdata.phys = desc.phys;
            mem_wdata.fault = fault_new;
            mem_wdata.wp = wp_new;
            valid_next[cur_idx] = 1'b1;
            done_next = 1'b1;
            state_next = ALP_ST_IDLE;
            if (fault_new) begin
              entry_fault_flag_next = 1'b1;
              ev[`ALP_EV_FAULT] = 1'b1;
            end else if (wp_new && cur_reg.write) begin
              entry_fault_flag_next = 1'b1;
              ev[`ALP_EV_WP] = 1'b1;
            end else begin
              phys_next = {desc.phys, cur_reg.addr[`ALP_PAGE_LSB-1:0]};
            end
          end
        end
      end
      default: begin
        state_next = ALP_ST_IDLE;
      end
    endcase
    if (flush) begin
      valid_next = '0;
    end
    ready_next = (state_next == ALP_ST_IDLE);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ALP_ST_IDLE;
      cur_reg <= '0;
      lvl_reg <= '0;
      min_ral_reg <= `ALP_LVL_MAX;
      min_wal_reg <= `ALP_LVL_MAX;
      wp_any_reg <= 1'b0;
      valid_reg <= '0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      entry_fault_flag_reg <= 1'b0;
      phys_reg <= '0;
      walk_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      lvl_reg <= lvl_next;
      min_ral_reg <= min_ral_next;
      min_wal_reg <= min_wal_next;
      wp_any_reg <= wp_any_next;
      valid_reg <= valid_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      entry_fault_flag_reg <= entry_fault_flag_next;
      phys_reg <= phys_next;
      walk_req_reg <= walk_req_next;
    end
  end

  // cache read follows the incoming address so data land in the check cycle
  alp_cache_mem u_cache (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(mem_wr),
    .wr_idx(cur_idx),
    .wr_data(mem_wdata),
    .rd_idx(cyc_req.addr[`ALP_PAGE_LSB+`ALP_IDX_W-1:`ALP_PAGE_LSB]),
    .rd_data(mem_rdata)
  );

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign cyc_ready = ready_reg;
  assign cyc_done = done_reg;
  assign cyc_entry_fault_flag = entry_fault_flag_reg;
  assign cyc_phys = phys_reg;
  assign walk_req = walk_req_reg;
  assign walk_cyc = cur_reg;
  assign walk_root = task_root_pointer_reg;
endmodule : alp_level_check

//--- verification/alp_level_check_monitor.sv
// concurrent checks on the access level block ports
`timescale 1ns/100ps
`include "alp_params.svh"
module alp_level_check_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [`ALP_RA_W-1:0] reg_addr,
  input wire logic [`ALP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`ALP_DW-1:0] reg_rdata,
  // bus cycle and search
  input wire logic cyc_valid,
  input wire alp_pkg::alp_cyc_t cyc_req,
  input wire logic cyc_ready,
  input wire logic cyc_done,
  input wire logic cyc_entry_fault_flag,
  input wire logic walk_req,
  input wire logic desc_valid,
  input wire alp_pkg::alp_desc_t desc
);
  import alp_pkg::*;
  logic en_reg, en_next;
  logic [1:0] lc_reg, lc_next;
  logic [2:0] task_reg, task_next, lvl;
  logic take, chk_hit;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // shadow of the enable, width and task level settings
  always_comb begin
    en_next = en_reg;
    lc_next = lc_reg;
    task_next = task_reg;
    if (reg_wr && reg_addr == `ALP_OFS_CTRL) begin
      en_next = reg_wdata[0];
      lc_next = reg_wdata[2:1];
    end
    if (reg_wr && reg_addr == `ALP_OFS_TASK) task_next = reg_wdata[2:0];
    case (lc_reg)
      2'h0: lvl = {2'h0, cyc_req.addr[31]};
      2'h1: lvl = {1'h0, cyc_req.addr[31:30]};
      default: lvl = cyc_req.addr[31:29];
    endcase
    take = cyc_valid && cyc_ready;
    chk_hit = take && en_reg && cyc_req.fc[3:2] == 2'h0 && lvl < task_reg;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_reg <= 1'b0;
      lc_reg <= 2'h0;
      task_reg <= 3'h0;
    end else begin
      en_reg <= en_next;
      lc_reg <= lc_next;
      task_reg <= task_next;
    end
  end
  take_drop_a: assert property (take |=> !cyc_ready)
    else $error("ready stayed high after a taken cycle");
  answer_time_a: assert property (take |-> ##2 (cyc_done || walk_req))
    else $error("no answer or search two cycles after take");
  task_abort_a: assert property (chk_hit |-> ##2 (cyc_done && cyc_entry_fault_flag))
    else $error("task level violation not aborted");
  entry_fault_flag_done_a: assert property (cyc_entry_fault_flag |-> cyc_done)
    else $error("bus error without done");
  done_pulse_a: assert property (cyc_done |=> !cyc_done)
    else $error("done longer than one cycle");
  walk_pulse_a: assert property (walk_req |=> !walk_req)
    else $error("search request longer than one cycle");
  last_done_a: assert property (desc_valid && desc.last |=> cyc_done)
    else $error("no answer after last descriptor");
  rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule : alp_level_check_monitor
bind alp_level_check alp_level_check_monitor u_mon (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_valid(cyc_valid),
  .cyc_req(cyc_req), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
  .cyc_entry_fault_flag(cyc_entry_fault_flag), .walk_req(walk_req), .desc_valid(desc_valid),
  .desc(desc));

//--- verification/alp_walk_model.sv
// table walker model: two long descriptors per search, with gaps
`timescale 1ns/100ps
module alp_walk_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // search request and path settings
  input wire logic walk_req,
  input wire logic [2:0] ral0,
  input wire logic [2:0] ral1,
  input wire logic [2:0] wal1,
  input wire logic wp1,
  // descriptor output
  output logic desc_valid,
  output alp_pkg::alp_desc_t desc
);
  import alp_pkg::*;
  logic [2:0] st;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= 3'h0;
      desc_valid <= 1'b0;
      desc <= '0;
    end else begin
      desc_valid <= st == 3'h2 || st == 3'h4;
      // idle data line toggles so stale values never look valid
      if (st == 3'h2) desc <= {1'b1, ral0, 3'h7, 1'b0, 1'b0, 20'h00000};
      else if (st == 3'h4) desc <= {1'b1, ral1, wal1, wp1, 1'b1, 20'hABCDE};
      else desc <= ~desc;
      if (walk_req) st <= 3'h1;
      else if (st != 3'h0) st <= (st == 3'h4) ? 3'h0 : st + 3'h1;
    end
  end
endmodule : alp_walk_model

//--- verification/tb.sv
// self-checking bench for the access level block
`timescale 1ns/100ps
module tb;
  import alp_pkg::*;
  logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, cyc_valid = 0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, cyc_phys, walk_root;
  alp_cyc_t cyc_req = '0, walk_cyc;
  alp_desc_t desc;
  logic cyc_ready, cyc_done, cyc_entry_fault_flag, walk_req, desc_valid, irq, wp1 = 0;
  logic [2:0] ral0 = 7, ral1 = 7, wal1 = 7;
  int fail_count = 0, checks_done = 0, cycles = 0;
  always #10 mclk = ~mclk;
  alp_level_check DUT (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cyc_valid(cyc_valid), .cyc_req(cyc_req),
    .cyc_ready(cyc_ready), .cyc_done(cyc_done), .cyc_entry_fault_flag(cyc_entry_fault_flag),
    .cyc_phys(cyc_phys), .walk_req(walk_req), .walk_cyc(walk_cyc),
    .walk_root(walk_root), .desc_valid(desc_valid), .desc(desc), .irq(irq));
  alp_walk_model u_walk (.mclk(mclk), .nrst(nrst), .walk_req(walk_req),
    .ral0(ral0), .ral1(ral1), .wal1(wal1), .wp1(wp1),
    .desc_valid(desc_valid), .desc(desc));
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 20000) begin
      fail_count++;
      test_done();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp, "register read");
  endtask : rd
  task cyc(input logic [31:0] a, input logic [3:0] f, input logic w,
           input logic eb, input logic ew);
    int n;
    logic sw;
    sw = 0;
    @(posedge mclk);
    cyc_valid <= 1;
    cyc_req <= {a, f, w};
    do @(posedge mclk); while (cyc_ready !== 1'b1);
    cyc_valid <= 0;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      #1 if (walk_req === 1'b1) sw = 1;
      if (cyc_done === 1'b1) break;
    end
    chk({31'h0, cyc_done}, 32'h1, "cycle done");
    chk({31'h0, cyc_entry_fault_flag}, {31'h0, eb}, "bus error");
    chk({31'h0, sw}, {31'h0, ew}, "search started");
    chk(walk_cyc.addr, a, "captured address");
    chk({28'h0, walk_cyc.fc}, {28'h0, f}, "captured function code");
  endtask : cyc
  task t_reset;
    for (int i = 0; i < 7; i++) rd(i[3:0], (i == 5) ? 32'h0000_01F8 : 32'h0);
    chk({31'h0, cyc_ready}, 32'h1, "ready after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    chk(walk_root, 32'h0, "root after reset");
    $display("reset test done");
  endtask : t_reset
  task t_task;
    wr(4'h0, 32'h5);
    wr(4'h1, 32'h3);
    wr(4'h2, 32'h0010_0000);
    rd(4'h2, 32'h0010_0000);
    chk(walk_root, 32'h0010_0000, "search root");
    wr(4'h4, 32'h7);
    cyc(32'h4000_1000, 4'h1, 0, 1, 0);
    rd(4'h3, 32'h1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(4'h3, 32'h1);
    rd(4'h3, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    cyc(32'h6000_2000, 4'h1, 0, 0, 1);
    chk(cyc_phys[31:12], 32'hABCDE, "physical page");
    cyc(32'h6000_2000, 4'h1, 0, 0, 0);
    chk(cyc_phys, 32'hABCD_E000, "hit physical address");
    cyc(32'h6000_2000, 4'h2, 0, 0, 1);
    cyc(32'h0000_3000, 4'h5, 0, 0, 1);
    $display("task level test done");
  endtask : t_task
  task t_search;
    ral0 = 6;
    ral1 = 3;
    cyc(32'hA000_4000, 4'h9, 0, 1, 1);
    rd(4'h3, 32'h2);
    wr(4'h3, 32'h7);
    ral0 = 7;
    ral1 = 5;
    wal1 = 2;
    cyc(32'hA000_5000, 4'h1, 1, 1, 1);
    rd(4'h5, 32'h0AD);
    rd(4'h3, 32'h4);
    wr(4'h3, 32'h7);
    cyc(32'hA000_5000, 4'h1, 0, 0, 0);
    wal1 = 7;
    wp1 = 1;
    cyc(32'hA000_6000, 4'h1, 1, 1, 1);
    wp1 = 0;
    $display("search test done");
  endtask : t_search
  task t_width;
    wr(4'h0, 32'h1);
    wr(4'h1, 32'h1);
    cyc(32'h0000_7000, 4'h1, 0, 1, 0);
    cyc(32'h8000_7000, 4'h1, 0, 0, 1);
    wr(4'h0, 32'h3);
    wr(4'h1, 32'h2);
    cyc(32'h4000_7000, 4'h1, 0, 1, 0);
    cyc(32'h8000_8000, 4'h1, 0, 0, 1);
    wr(4'h3, 32'h7);
    $display("width test done");
  endtask : t_width
  task t_off;
    // disabled with three-bit levels: level 1 is below task level 2
    // and above every read level and the last write level on the path
    wr(4'h0, 32'h4);
    ral0 = 0;
    ral1 = 0;
    wal1 = 0;
    cyc(32'h2000_9000, 4'h1, 1, 0, 1);
    $display("disabled test done");
  endtask : t_off
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_task();
    t_search();
    t_width();
    t_off();
    test_done();
  end
endmodule : tb
